// file: qdws_write_slave.sv
// Write-path slave of a four-channel 16-bit converter on a two-wire bus.
// Assumes SCL_IN from the bus master as link clock, SDA resolved outside.
// Operation
// - A write opens with the seven-bit address and write bit, then the control byte.
// - The control byte selects the load action and one of four channels.
// - Control bits: 7:6 extended address, 5:4 load, 3 unused, 2:1 channel, 0 power-down.
// - Control bit 0 clear means conversion data follows, set means power-down data.
// - Conversion data arrives as high then low byte, repeating until stop or start.
// - Further byte pairs reuse the stored control byte without a new header.
// - A power-down write takes exactly two bytes after the control byte.
// - Matching address, control and data bytes are acknowledged by pulling data low.
// - The high-speed master code is never acknowledged.
// - The channel update happens at the falling clock edge ending the low-byte acknowledge.
// - Each channel holds 18 bits: two power-down bits above sixteen data bits.
`timescale 1ns/1ns
`default_nettype none

module qdws_write_slave
  import qdws_pkg::*;
(
  // System clock and reset
  input wire logic CLOCK_IN,
  input wire logic SRST_IN,
  // Two-wire bus
  input wire logic SCL_IN,
  input wire logic SDA_IN,
  output logic SDA_OUT,
  output logic SDA_OE_OUT,
  // Address straps
  input wire logic PIN_ADDR_HI_IN,
  input wire logic PIN_ADDR_LO_IN,
  // Channel update results
  output logic UPDATE_OUT,
  output logic [1:0] CHAN_OUT,
  output logic [1:0] LOAD_SEL_OUT,
  output logic PD_WRITE_OUT,
  output logic [17:0] HOLD0_OUT,
  output logic [17:0] HOLD1_OUT,
  output logic [17:0] HOLD2_OUT,
  output logic [17:0] HOLD3_OUT
);

  // ----------------------------------------
  // State types
  // ----------------------------------------
  typedef struct packed {
    logic sda_rise;
  } qdws_rise_t;

  typedef struct packed {
    logic rst_s1;
    logic rst_s2;
    logic [1:0] pin_s1;
    logic [1:0] pin_s2;
    qdws_phase_t phase;
    logic [3:0] bitcnt;
    logic [7:0] shreg;
    logic ack;
    logic [7:0] ctrl;
    logic [7:0] hi;
    logic [17:0] upd_word;
    logic [1:0] upd_chan;
    logic [1:0] upd_load;
    logic upd_pd;
    logic upd_tgl;
  } qdws_link_t;

  typedef struct packed {
    logic tgl_s1;
    logic tgl_s2;
    logic tgl_s3;
    logic strobe;
    logic [1:0] chan;
    logic [1:0] load;
    logic pd;
    logic [3:0][17:0] hold;
  } qdws_sys_t;

  qdws_rise_t r, next_r;
  qdws_link_t l, next_l;
  qdws_sys_t s, next_s;
  logic start_seen;
  logic stop_seen;
  logic [6:0] own_addr;
  logic [7:0] next_byte;

  // Acknowledge decision for a just-received byte
  function automatic logic byte_accepted(qdws_phase_t ph, logic [7:0] b, logic [6:0] own);
    case (ph)
      PH_ADDR: byte_accepted = (b == {own, 1'b0});
      PH_CTRL, PH_HIGH, PH_LOW: byte_accepted = 1'b1;
      default: byte_accepted = 1'b0;
    endcase
  endfunction

  // ----------------------------------------
  // Link side: data sampled while clock rises
  // ----------------------------------------
  always_comb begin
    next_r = r;
    next_r.sda_rise = SDA_IN;
  end

  always_ff @(posedge SCL_IN) begin
    r <= next_r;
  end

  // ----------------------------------------
  // Link side: protocol on the falling clock
  // ----------------------------------------
  // Data changing within one high phase marks a start or a stop.
  assign start_seen = r.sda_rise && !SDA_IN;
  assign stop_seen = !r.sda_rise && SDA_IN;
  assign own_addr = {ADDR_PREFIX, l.pin_s2};
  assign next_byte = {l.shreg[6:0], r.sda_rise};

  always_comb begin
    next_l = l;
    next_l.rst_s1 = SRST_IN;
    next_l.rst_s2 = l.rst_s1;
    next_l.pin_s1 = {PIN_ADDR_HI_IN, PIN_ADDR_LO_IN};
    next_l.pin_s2 = l.pin_s1;
    if (l.rst_s2) begin
      next_l.phase = PH_IDLE;
      next_l.bitcnt = 4'h0;
      next_l.shreg = BYTE_RESET;
      next_l.ack = 1'b0;
      next_l.ctrl = BYTE_RESET;
      next_l.hi = BYTE_RESET;
      next_l.upd_word = HOLD_RESET;
      next_l.upd_chan = 2'h0;
      next_l.upd_load = 2'h0;
      next_l.upd_pd = 1'b0;
      next_l.upd_tgl = 1'b0;
    end else if (start_seen) begin
      next_l.phase = PH_ADDR;
      next_l.bitcnt = 4'h0;
      next_l.ack = 1'b0;
    end else if (stop_seen) begin
      next_l.phase = PH_IDLE;
      next_l.ack = 1'b0;
    end else if (l.phase != PH_IDLE) begin
      if (l.bitcnt == ACK_BIT) begin
        next_l.ack = 1'b0;
        next_l.bitcnt = 4'h0;
        case (l.phase)
          PH_ADDR: begin
            if (l.shreg == {own_addr, 1'b0}) begin
              next_l.phase = PH_CTRL;
            end else if (l.shreg[7:3] == MCODE_PREFIX) begin
              next_l.phase = PH_ADDR;
            end else begin
              next_l.phase = PH_IDLE;
            end
          end
          PH_CTRL: begin
            next_l.ctrl = l.shreg;
            next_l.phase = PH_HIGH;
          end
          PH_HIGH: begin
            next_l.hi = l.shreg;
            next_l.phase = PH_LOW;
          end
          PH_LOW: begin
            // Update leaves at the falling edge that ends this acknowledge
            if (l.ctrl[CTRL_PD_BIT]) begin
              next_l.upd_word = {l.hi[7:6], 16'h0000};
              next_l.phase = PH_DONE;
            end else begin
              next_l.upd_word = {2'b00, l.hi, l.shreg};
              next_l.phase = PH_HIGH;
            end
            next_l.upd_chan = l.ctrl[CTRL_CHAN_MSB:CTRL_CHAN_LSB];
            next_l.upd_load = l.ctrl[CTRL_LOAD_MSB:CTRL_LOAD_LSB];
            next_l.upd_pd = l.ctrl[CTRL_PD_BIT];
            next_l.upd_tgl = !l.upd_tgl;
          end
          default: next_l.phase = PH_IDLE;
        endcase
      end else begin
        next_l.shreg = next_byte;
        next_l.bitcnt = 4'(l.bitcnt + 4'h1);
        if (l.bitcnt == LAST_DATA_BIT) begin
          next_l.ack = byte_accepted(l.phase, next_byte, own_addr);
        end
      end
    end
  end

  always_ff @(negedge SCL_IN) begin
    l <= next_l;
  end

  // Open-drain data: only ever pulled low
  assign SDA_OUT = 1'b0;
  assign SDA_OE_OUT = l.ack && !SRST_IN;

  // ----------------------------------------
  // System side: holding registers
  // ----------------------------------------
  always_comb begin
    next_s = s;
    next_s.tgl_s1 = l.upd_tgl;
    next_s.tgl_s2 = s.tgl_s1;
    next_s.tgl_s3 = s.tgl_s2;
    next_s.strobe = 1'b0;
    if (SRST_IN) begin
      next_s.strobe = 1'b0;
      next_s.chan = 2'h0;
      next_s.load = 2'h0;
      next_s.pd = 1'b0;
      for (int i = 0; i < 4; i++) begin
        next_s.hold[i] = HOLD_RESET;
      end
    end else if (s.tgl_s2 != s.tgl_s3) begin
      // Link fields change with the toggle and stay stable for many bus clocks after it
      next_s.strobe = 1'b1;
      next_s.chan = l.upd_chan;
      next_s.load = l.upd_load;
      next_s.pd = l.upd_pd;
      if (l.upd_pd) begin
        next_s.hold[l.upd_chan][17:16] = l.upd_word[17:16];
      end else begin
        next_s.hold[l.upd_chan] = l.upd_word;
      end
    end
  end

  always_ff @(posedge CLOCK_IN) begin
    s <= next_s;
  end

  assign UPDATE_OUT = s.strobe;
  assign CHAN_OUT = s.chan;
  assign LOAD_SEL_OUT = s.load;
  assign PD_WRITE_OUT = s.pd;
  assign HOLD0_OUT = s.hold[0];
  assign HOLD1_OUT = s.hold[1];
  assign HOLD2_OUT = s.hold[2];
  assign HOLD3_OUT = s.hold[3];

  // ----------------------------------------
  // Assertions
  // ----------------------------------------
  logic ack_end;
  assign ack_end = (l.bitcnt == ACK_BIT) && !start_seen && !stop_seen;

  a_mcode_no_ack: assert property (@(negedge SCL_IN) disable iff (l.rst_s2)
    ack_end && l.phase == PH_ADDR && l.shreg[7:3] == MCODE_PREFIX |-> !l.ack ##1 l.phase == PH_ADDR)
    else $error("master code was acknowledged");
  a_addr_ack: assert property (@(negedge SCL_IN) disable iff (l.rst_s2)
    ack_end && l.phase == PH_ADDR && l.shreg == {own_addr, 1'b0} |-> l.ack ##1 l.phase == PH_CTRL)
    else $error("own write address not acknowledged");
  a_addr_miss: assert property (@(negedge SCL_IN) disable iff (l.rst_s2)
    ack_end && l.phase == PH_ADDR && l.shreg != {own_addr, 1'b0} && l.shreg[7:3] != MCODE_PREFIX
    |-> !l.ack ##1 (l.phase == PH_IDLE && !l.ack))
    else $error("foreign address not ignored");
  a_ctrl_store: assert property (@(negedge SCL_IN) disable iff (l.rst_s2)
    ack_end && l.phase == PH_CTRL |-> l.ack ##1 (l.phase == PH_HIGH && l.ctrl == $past(l.shreg)))
    else $error("control byte not taken");
  a_pair_reuse: assert property (@(negedge SCL_IN) disable iff (l.rst_s2)
    ack_end && l.phase == PH_LOW && !l.ctrl[CTRL_PD_BIT] |=> l.phase == PH_HIGH && $stable(l.ctrl))
    else $error("data pair did not loop to high byte");
  a_low_update: assert property (@(negedge SCL_IN) disable iff (l.rst_s2)
    ack_end && l.phase == PH_LOW |=> l.upd_tgl != $past(l.upd_tgl)
      && l.upd_chan == $past(l.ctrl[2:1]) && l.upd_load == $past(l.ctrl[5:4]))
    else $error("no update at end of low byte acknowledge");
  a_data_word: assert property (@(negedge SCL_IN) disable iff (l.rst_s2)
    ack_end && l.phase == PH_LOW && !l.ctrl[CTRL_PD_BIT]
    |=> l.upd_word == {2'b00, $past(l.hi), $past(l.shreg)} && !l.upd_pd)
    else $error("data word assembled wrongly");
  a_pd_two_bytes: assert property (@(negedge SCL_IN) disable iff (l.rst_s2)
    ack_end && l.phase == PH_LOW && l.ctrl[CTRL_PD_BIT] |=> l.phase == PH_DONE && l.upd_pd
      ##[1:9] (l.bitcnt == ACK_BIT && !l.ack) || l.phase != PH_DONE)
    else $error("third power-down byte acknowledged");
  a_hold_write: assert property (@(posedge CLOCK_IN) disable iff (SRST_IN)
    s.tgl_s2 != s.tgl_s3 && !l.upd_pd |=> s.strobe && s.hold[s.chan] == $past(l.upd_word))
    else $error("holding register not written");

  c_data_pair: cover property (@(negedge SCL_IN) disable iff (l.rst_s2)
    ack_end && l.phase == PH_LOW && !l.ctrl[CTRL_PD_BIT]);
  c_pd_write: cover property (@(negedge SCL_IN) disable iff (l.rst_s2)
    ack_end && l.phase == PH_LOW && l.ctrl[CTRL_PD_BIT]);
  c_mcode: cover property (@(negedge SCL_IN) disable iff (l.rst_s2)
    ack_end && l.phase == PH_ADDR && l.shreg[7:3] == MCODE_PREFIX);
  c_addr_miss: cover property (@(negedge SCL_IN) disable iff (l.rst_s2)
    ack_end && l.phase == PH_ADDR && !l.ack && l.shreg[7:3] != MCODE_PREFIX);

endmodule

`default_nettype wire

// file: qdws_pkg.sv
// Constants, codes and phase encoding of the two-wire write slave.
// Assumes a 100 MHz system clock and a bus clock from an outside master.
package qdws_pkg;

  // ----------------------------------------
  // Address and byte codes
  // ----------------------------------------
  localparam logic [4:0] ADDR_PREFIX = 5'h13;
  localparam logic [4:0] MCODE_PREFIX = 5'h01;
  localparam logic [3:0] ACK_BIT = 4'h8;
  localparam logic [3:0] LAST_DATA_BIT = 4'h7;

  // ----------------------------------------
  // Control byte fields
  // ----------------------------------------
  localparam int CTRL_EXT_MSB = 7;
  localparam int CTRL_EXT_LSB = 6;
  localparam int CTRL_LOAD_MSB = 5;
  localparam int CTRL_LOAD_LSB = 4;
  localparam int CTRL_CHAN_MSB = 2;
  localparam int CTRL_CHAN_LSB = 1;
  localparam int CTRL_PD_BIT = 0;

  // ----------------------------------------
  // Reset values
  // ----------------------------------------
  localparam logic [17:0] HOLD_RESET = 18'h00000;
  localparam logic [7:0] BYTE_RESET = 8'h00;

  // ----------------------------------------
  // Link phases
  // ----------------------------------------
  typedef enum logic [2:0] {
    PH_IDLE = 3'b000,
    PH_ADDR = 3'b001,
    PH_CTRL = 3'b010,
    PH_HIGH = 3'b011,
    PH_LOW = 3'b100,
    PH_DONE = 3'b101
  } qdws_phase_t;

endpackage

// file: qdws_bus_master.sv
// Behavioural bus master that drives the two-wire write slave.
// Assumes the bench resolves the open-drain data line and feeds it back.
`timescale 1ns/1ns
`default_nettype none

module qdws_bus_master (
  // Bus lines
  output logic scl_out,
  output logic sda_out,
  input wire logic sda_in
);
  // ----------------------------------------
  // Bus clocking
  // ----------------------------------------
  initial begin
    scl_out = 1'b0;
    sda_out = 1'b1;
  end

  // One 32 ns clock; data moves 8 ns after the fall, mid moves it while high
  task automatic pulse(input logic b, input logic mid, output logic s);
    sda_out = b;
    #8 scl_out = 1'b1;
    #8 s = sda_in;
    sda_out = mid;
    #8 scl_out = 1'b0;
    #8;
  endtask

  // Also serves as repeated start when no stop came first
  task automatic start_cond();
    logic s;
    pulse(1'b1, 1'b0, s);
  endtask

  task automatic stop_cond();
    logic s;
    pulse(1'b0, 1'b1, s);
  endtask

  task automatic idle(input int n);
    logic s;
    repeat (n) pulse(1'b1, 1'b1, s);
  endtask

  // Most significant bit first, then a released ninth clock
  task automatic send_byte(input logic [7:0] b, output logic ack);
    logic s;
    for (int i = 7; i >= 0; i--) pulse(b[i], b[i], s);
    pulse(1'b1, 1'b1, s);
    ack = ~s;
  endtask
endmodule
`default_nettype wire

// file: quad_dac_i2c_write_slave_tb.sv
// Self-checking bench of the two-wire write slave.
// Assumes qdws_bus_master drives the bus; the line has a pull-up.
`timescale 1ns/1ns
`default_nettype none
`define CHK(nm, e, a) begin total_checks++; if ((a) !== (e)) begin \
  $display("MISMATCH %s exp=%h got=%h", nm, e, a); miscompares++; end end

module quad_dac_i2c_write_slave_tb;
  import qdws_pkg::*;
  logic clock = 1'b0;
  logic srst = 1'b1;
  logic hi = 1'b1;
  logic lo = 1'b0;
  logic m_sda, scl, sda_o, sda_oe, upd, pdw;
  logic [1:0] chan, lsel;
  wire logic [17:0] hold [4];
  wire logic sda_w = m_sda & (sda_oe ? sda_o : 1'b1);
  logic [31:0] seed = 32'h008d1788;
  logic [17:0] exp_hold [4] = '{default: HOLD_RESET};
  logic [4:0] exp_last = 5'h00;
  logic [4:0] last = 5'h00;
  int n_upd = 0;
  int exp_n = 0;
  int miscompares = 0;
  int total_checks = 0;

  qdws_write_slave u_dut (.CLOCK_IN(clock), .SRST_IN(srst), .SCL_IN(scl), .SDA_IN(sda_w),
    .SDA_OUT(sda_o), .SDA_OE_OUT(sda_oe), .PIN_ADDR_HI_IN(hi), .PIN_ADDR_LO_IN(lo),
    .UPDATE_OUT(upd), .CHAN_OUT(chan), .LOAD_SEL_OUT(lsel), .PD_WRITE_OUT(pdw),
    .HOLD0_OUT(hold[0]), .HOLD1_OUT(hold[1]), .HOLD2_OUT(hold[2]), .HOLD3_OUT(hold[3]));

  qdws_bus_master m (.scl_out(scl), .sda_out(m_sda), .sda_in(sda_w));

  // ----------------------------------------
  // Helpers
  // ----------------------------------------
  function automatic logic [31:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction

  // Expected holding register after a completed pair
  function automatic logic [17:0] hold_after(input logic [17:0] old, input logic [7:0] ctl,
                                             input logic [7:0] hb, input logic [7:0] lb);
    if (ctl[0]) return {hb[7:6], old[15:0]};
    return {2'b00, hb, lb};
  endfunction

  always @(posedge clock) begin
    if (upd === 1'b1) begin
      n_upd++;
      last = {pdw, lsel, chan};
    end
  end

  task automatic end_sim();
    $display("Checks %0d, mismatches %0d", total_checks, miscompares);
    if (miscompares == 0 && total_checks > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask

  task automatic frame(input logic [7:0] adr, input logic [7:0] ctl, input logic [7:0] d[$],
                       input bit stop);
    logic ack;
    logic acc;
    acc = (adr[7:1] == {ADDR_PREFIX, hi, lo}) && !adr[0];
    m.start_cond();
    m.send_byte(adr, ack);
    `CHK("addr_ack", acc, ack)
    m.send_byte(ctl, ack);
    `CHK("ctrl_ack", acc, ack)
    for (int i = 0; i < d.size(); i++) begin
      m.send_byte(d[i], ack);
      `CHK("data_ack", acc && (!ctl[0] || i < 2), ack)
      if (acc && i[0] && (!ctl[0] || i == 1)) begin
        exp_n++;
        exp_last = {ctl[0], ctl[5:4], ctl[2:1]};
        exp_hold[ctl[2:1]] = hold_after(exp_hold[ctl[2:1]], ctl, d[i-1], d[i]);
        repeat (6) @(posedge clock);
        `CHK("updates", exp_n, n_upd)
      end
    end
    if (stop) m.stop_cond();
    repeat (8) @(posedge clock);
    `CHK("update_count", exp_n, n_upd)
    `CHK("last_info", exp_last, last)
    for (int c = 0; c < 4; c++) `CHK("hold", exp_hold[c], hold[c])
  endtask

  // ----------------------------------------
  // Stimulus
  // ----------------------------------------
  initial begin
    forever #5 clock = ~clock;
  end

  initial begin
    #500000;
    miscompares++;
    end_sim();
  end

  initial begin
    logic [7:0] d[$];
    logic [7:0] adr;
    logic ack;
    logic [31:0] rv;
    fork
      m.idle(12);
      begin
        repeat (20) @(posedge clock);
        srst <= 1'b0;
      end
    join
    for (int k = 0; k < 24; k++) begin
      d = {};
      rv = rnd();
      // Straps move between frames so more than one own address is exercised
      @(posedge clock);
      {hi, lo} <= rv[9:8];
      @(posedge clock);
      adr = {ADDR_PREFIX, rv[9:8], 1'b0};
      if (k == 13) adr[0] = 1'b1;
      if (k == 14) adr[1] = ~adr[1];
      if (k % 5 == 0) begin
        m.start_cond();
        m.send_byte({5'h01, 3'(rnd())}, ack);
        `CHK("mcode_ack", 1'b0, ack)
      end
      if (k[2]) begin
        d.push_back({2'(rnd() >> 6), 6'h00});
        d.push_back(8'h00);
        if (k[0]) d.push_back(8'(rnd()));
      end else begin
        repeat (k[0] ? 4 : 2) d.push_back(8'(rnd()));
        if (k[3]) d.push_back(8'(rnd()));
      end
      frame(adr, {2'(rnd() >> 6), k[3:2], 1'(rnd() >> 3), k[1:0], k[2]}, d, k[1]);
      $display("Test %0d done", k);
    end
    end_sim();
  end
endmodule
`default_nettype wire
